// ---- ascd_bench.sv ----
// Self-checking bench: serial master and converter end joined by their link.
// Assumes the package, the interface and both ends are compiled before it.
`timescale 1ns/1ps
module ascd_bench;
  // ==========================================
  // Rows: command, sample, expected decode and result
  typedef struct packed {
    logic [7:0] cmd;
    logic [9:0] code;
    logic [2:0] pos;
    logic [2:0] neg;
    logic uni;
    logic sgl;
    logic [1:0] mode;
    logic [9:0] res;
  } ascd_row_t;
  localparam int HALF = 10;
  ascd_row_t rows [7] = '{
    '{8'hff, 10'h2a5, 3'h7, 3'h0, 1'h1, 1'h1, 2'h3, 10'h2a5},
    '{8'h8b, 10'h0c3, 3'h0, 3'h1, 1'h1, 1'h0, 2'h3, 10'h0c3},
    '{8'hd7, 10'h3ff, 3'h3, 3'h0, 1'h0, 1'h1, 2'h3, 10'h1ff},
    '{8'hb3, 10'h001, 3'h6, 3'h7, 1'h0, 1'h0, 2'h3, 10'h201},
    '{8'hae, 10'h155, 3'h4, 3'h0, 1'h1, 1'h1, 2'h2, 10'h000},
    '{8'h99, 10'h000, 3'h2, 3'h3, 1'h1, 1'h0, 2'h1, 10'h000},
    '{8'h0f, 10'h000, 3'h7, 3'h6, 1'h0, 1'h0, 2'h0, 10'h000}
  };
  logic sys_clk;
  logic rst_b;
  logic [4:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic irq;
  logic [9:0] sample_code;
  logic [2:0] chan_pos;
  logic [2:0] chan_neg;
  logic neg_is_ground;
  logic polarity_unipolar;
  logic pairing_single;
  logic [1:0] clock_mode;
  logic conv_start;
  logic full_power_down;
  logic fast_power_down;
  logic sclk_d;
  logic [23:0] strb_seen;
  logic conv_busy;
  logic [23:0] busy_seen;
  logic [31:0] rd;
  int conv_cnt = 0;
  int mismatches;
  int checks_done;
  // ==========================================
  // Ends, link and checker
  ascd_if link_bus();
  ascd_host #(.HALF_CYC(HALF)) i_ascd_host (.sys_clk(sys_clk), .rst_b(rst_b), .ce(1'b1),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq), .link(link_bus));
  ascd_dev #(.INT_CONV_CYC(20)) i_ascd_dev (.sys_clk(sys_clk), .rst_b(rst_b), .ce(1'b1), .link(link_bus),
    .sample_code(sample_code), .chan_pos(chan_pos), .chan_neg(chan_neg), .neg_is_ground(neg_is_ground),
    .polarity_unipolar(polarity_unipolar), .pairing_single(pairing_single), .clock_mode(clock_mode),
    .conv_start(conv_start), .conv_busy(conv_busy), .full_power_down(full_power_down),
    .fast_power_down(fast_power_down));
  ascd_checker #(.HALF_CYC(HALF)) i_ascd_checker (.sys_clk(sys_clk), .rst_b(rst_b), .cs_n(link_bus.cs_n),
    .sclk(link_bus.sclk), .din(link_bus.din), .dout(link_bus.dout), .dout_oe(link_bus.dout_oe),
    .strobe(link_bus.strobe));
  always #4 sys_clk = ~sys_clk;
  // Strobe is sampled at falls, a full half period after it may move
  always @(posedge sys_clk) begin
    sclk_d <= link_bus.sclk;
    if (conv_start === 1'b1) conv_cnt <= conv_cnt + 1;
    if (sclk_d && !link_bus.sclk && !link_bus.cs_n) begin
      strb_seen <= {strb_seen[22:0], link_bus.strobe_line};
      busy_seen <= {busy_seen[22:0], conv_busy};
    end
  end
  // ==========================================
  // Tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic give_up();
    mismatches++;
    tally_and_finish();
  endtask
  task automatic bus(input logic wr, input logic [4:0] adr, input logic [31:0] wd, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge sys_clk);
    avs_address <= adr;
    avs_writedata <= wd;
    avs_write <= wr;
    avs_read <= ~wr;
    // Waitrequest and read data are taken as they stood at each rising edge
    do begin
      @(posedge sys_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (avs_waitrequest !== 1'b0) give_up();
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    // Let the outputs settle before the caller compares them
    @(negedge sys_clk);
  endtask
  task automatic wait_irq();
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 3000) begin
      n++;
      @(negedge sys_clk);
    end
    if (n == 3000) give_up();
  endtask
  task automatic run_row(input ascd_row_t r);
    int c0;
    c0 = conv_cnt;
    @(posedge sys_clk);
    sample_code <= r.code;
    bus(1'b1, ascd_pkg::REG_CMD, {24'h0, r.cmd}, rd);
    wait_irq();
    bus(1'b0, ascd_pkg::REG_RESULT, 32'h0, rd);
    if (r.mode == ascd_pkg::MODE_EXT) begin
      check(rd, {20'h0, r.res, 2'h0});
      check(strb_seen[15:0], 16'h8000);
      check(busy_seen, 24'h00fe00);
    end
    check({chan_pos, chan_neg, neg_is_ground}, {r.pos, r.neg, r.sgl});
    check({polarity_unipolar, pairing_single, clock_mode}, {r.uni, r.sgl, r.mode});
    check({full_power_down, fast_power_down}, {r.mode == 2'h0, r.mode == 2'h1});
    check(conv_cnt - c0, r.mode[1]);
    bus(1'b1, ascd_pkg::REG_IRQ_CLR, 32'h3, rd);
    check(irq, 1'h0);
  endtask
  // ==========================================
  // Main sequence
  initial begin
    sys_clk = 1'b0;
    rst_b = 1'b0;
    avs_address = 5'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    sample_code = 10'h000;
    mismatches = 0;
    checks_done = 0;
    repeat (4) @(posedge sys_clk);
    rst_b <= 1'b1;
    bus(1'b1, ascd_pkg::REG_IRQ_EN, 32'h1, rd);
    foreach (rows[i]) begin
      run_row(rows[i]);
    end
    // Command written while busy must be dropped
    @(posedge sys_clk);
    sample_code <= 10'h3c3;
    bus(1'b1, ascd_pkg::REG_CMD, 32'hff, rd);
    bus(1'b1, ascd_pkg::REG_CMD, 32'h8f, rd);
    bus(1'b0, ascd_pkg::REG_CMD, 32'h0, rd);
    check(rd, 32'hff);
    bus(1'b0, ascd_pkg::REG_STATUS, 32'h0, rd);
    check(rd[0], 1'h1);
    wait_irq();
    check({chan_pos, clock_mode}, {3'h7, 2'h3});
    bus(1'b0, ascd_pkg::REG_RESULT, 32'h0, rd);
    check(rd, {20'h0, 10'h3c3, 2'h0});
    bus(1'b0, ascd_pkg::REG_IRQ_STAT, 32'h0, rd);
    check(rd, 32'h3);
    // Interrupt masking and clearing, unmapped and read-only places
    bus(1'b1, ascd_pkg::REG_IRQ_EN, 32'h0, rd);
    check(irq, 1'h0);
    bus(1'b1, ascd_pkg::REG_IRQ_EN, 32'h2, rd);
    check(irq, 1'h1);
    bus(1'b1, ascd_pkg::REG_IRQ_CLR, 32'h3, rd);
    check(irq, 1'h0);
    bus(1'b1, ascd_pkg::REG_STATUS, 32'hffff, rd);
    bus(1'b0, ascd_pkg::REG_STATUS, 32'h0, rd);
    check(rd[1:0], 2'h2);
    bus(1'b0, 5'h1c, 32'h0, rd);
    check(rd, 32'h0);
    // Second reset in mid-run
    @(posedge sys_clk);
    rst_b <= 1'b0;
    @(negedge sys_clk);
    check({link_bus.cs_n, link_bus.sclk, link_bus.din, link_bus.strobe_line, irq}, 5'h12);
    check({chan_pos, chan_neg, neg_is_ground, polarity_unipolar, pairing_single, clock_mode}, 11'h01e);
    repeat (4) @(posedge sys_clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge sys_clk);
    bus(1'b0, ascd_pkg::REG_IRQ_EN, 32'h0, rd);
    check(rd, 32'h0);
    bus(1'b0, ascd_pkg::REG_STATUS, 32'h0, rd);
    check(rd, 32'h0);
    tally_and_finish();
  end
endmodule

// ---- ascd_checker.sv ----
// Concurrent checks on the converter link between the two ends.
// Assumes the link signals, the system clock and its reset as plain inputs.
`timescale 1ns/1ps
module ascd_checker #(
  parameter int HALF_CYC = ascd_pkg::SCLK_HALF_CYC
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic din,
  input wire logic dout,
  input wire logic dout_oe,
  input wire logic strobe
);
  // ==========================================
  // Helper counters
  logic sclk_q_r;
  logic [5:0] rise_cnt_r;
  logic [5:0] rise_cnt_nxt;
  logic [7:0] high_cnt_r;
  logic [7:0] high_cnt_nxt;
  assign rise_cnt_nxt = cs_n ? 6'h00 : rise_cnt_r + {5'h00, sclk & ~sclk_q_r};
  assign high_cnt_nxt = sclk ? high_cnt_r + 8'h01 : 8'h00;
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      sclk_q_r <= 1'b0;
      rise_cnt_r <= 6'h00;
      high_cnt_r <= 8'h00;
    end else begin
      sclk_q_r <= sclk;
      rise_cnt_r <= rise_cnt_nxt;
      high_cnt_r <= high_cnt_nxt;
    end
  end
  // ==========================================
  // Assertions
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  a_sclk_idle_low: assert property (cs_n |-> !sclk) else $error("link clock moved while deselected");
  a_lead_half_low: assert property ($fell(cs_n) |-> (!sclk) [*8]) else $error("no low lead-in");
  a_din_held_high: assert property ($rose(sclk) |-> $stable(din) [*8]) else $error("data in moved early");
  a_half_period: assert property ($fell(sclk) |-> high_cnt_r == 8'(HALF_CYC)) else $error("clock high time");
  a_frame_rises: assert property ($rose(cs_n) |-> rise_cnt_r == 6'h18) else $error("frame not three bytes");
  a_dout_released: assert property (cs_n [*8] |-> !dout_oe) else $error("data out driven while idle");
  a_dout_driven: assert property ((!cs_n) [*8] |-> dout_oe) else $error("data out not driven");
  // Margin of ten cycles covers the synchroniser and output register delay
  a_dout_on_fall: assert property ($changed(dout) && !cs_n && !$past(cs_n, 12) |-> !sclk && $past(sclk, 10))
    else $error("data out moved off a falling edge");
  a_strobe_on_fall: assert property ($fell(strobe) && !cs_n && !$past(cs_n, 12) |-> !sclk && $past(sclk, 10))
    else $error("strobe fell off a falling edge");
endmodule

// ---- ascd_dev.sv ----
// Converter end: start bit search, control byte capture, decode and result shift-out.
// Assumes sys_clk at least eight times the link clock; the analog side supplies sample_code.
`timescale 1ns/1ps
// Function
// - Convert only after a fresh control byte
// - Constant high input repeats channel seven
// - Strobe one clock before result MSB
// - Back-to-back conversions take fifteen clocks
// - Strobe and data change on falling edges, except the internal-mode strobe rise at conversion end and the strobe fall at a select fall
// - Sample input on rising edges, select low
// - Skip zeros, first one starts byte
// - Master uses clock polarity and phase zero
// - Master uses three byte transfers
// - Decode start, select, polarity, pairing, mode
// - Bit three picks unipolar or bipolar
// - Bit two picks single-ended or differential
// - Mode bits pick power-down or clock
// - Single-ended channel weights mid, lo, hi
// - Differential pairs, high bit picks polarity
// - MSB first, binary or two's complement
// - Conversion begins falling edge after bit eight
// - Data output released while select high
module ascd_dev #(
  parameter int INT_CONV_CYC = ascd_pkg::INT_CONV_CYC
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic ce,
  ascd_if.dev link,
  input wire logic [ascd_pkg::RES_BITS-1:0] sample_code,
  output logic [2:0] chan_pos,
  output logic [2:0] chan_neg,
  output logic neg_is_ground,
  output logic polarity_unipolar,
  output logic pairing_single,
  output logic [1:0] clock_mode,
  output logic conv_start,
  output logic conv_busy,
  output logic full_power_down,
  output logic fast_power_down
);
  localparam int CW = $clog2(INT_CONV_CYC + 1);

  generate
    if (INT_CONV_CYC < 1) begin : g_chk
      $error("INT_CONV_CYC must be at least one");
    end
  endgenerate

  typedef enum logic [2:0] {RX_SEARCH, RX_SHIFT, RX_WAIT, RX_BUSY, RX_INT} ascd_rx_t;

  // ==========================================
  // Pin synchronisers
  logic [2:0] s1_r;
  logic [2:0] s2_r;
  logic [2:0] s3_r;
  logic [2:0] filt_r;
  logic [2:0] prev_r;
  wire [2:0] filt_nxt = (s2_r & ~(s2_r ^ s3_r)) | (filt_r & (s2_r ^ s3_r));

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      s1_r <= 3'h2;
      s2_r <= 3'h2;
      s3_r <= 3'h2;
      filt_r <= 3'h2;
      prev_r <= 3'h2;
    end else if (ce) begin
      s1_r <= {link.din, link.cs_n, link.sclk};
      s2_r <= s1_r;
      s3_r <= s2_r;
      filt_r <= filt_nxt;
      prev_r <= filt_r;
    end
  end

  wire cs_low = ~filt_r[ascd_pkg::LN_CS];
  wire cs_fall = cs_low & prev_r[ascd_pkg::LN_CS];
  wire sclk_rise = filt_r[ascd_pkg::LN_SCLK] & ~prev_r[ascd_pkg::LN_SCLK];
  wire sclk_fall = ~filt_r[ascd_pkg::LN_SCLK] & prev_r[ascd_pkg::LN_SCLK];
  wire din_bit = filt_r[ascd_pkg::LN_DIN];
  // Clock edges with select high never reach the capture logic
  wire take_bit = sclk_rise & cs_low;

  // ==========================================
  // Control byte capture
  ascd_rx_t rx_r;
  ascd_rx_t rx_nxt;
  logic [2:0] bit_cnt_r;
  logic [5:0] ctrl_sh_r;
  logic [6:0] ctrl_r;
  logic [CW-1:0] int_cnt_r;
  logic [3:0] out_left_r;

  wire [7:0] ctrl_byte = {1'b1, ctrl_r};
  wire [1:0] mode_sel = {ctrl_byte[ascd_pkg::CB_MODE_HI], ctrl_byte[ascd_pkg::CB_MODE_LO]};
  wire begin_conv = (rx_r == RX_WAIT) & sclk_fall;
  wire ext_load = begin_conv & (mode_sel == ascd_pkg::MODE_EXT);
  wire int_start = begin_conv & (mode_sel == ascd_pkg::MODE_INT);
  wire int_done = (rx_r == RX_INT) & (int_cnt_r == '0);
  wire b3_out = (rx_r == RX_BUSY) & sclk_fall & (out_left_r == ascd_pkg::B3_LEFT);

  always_comb begin
    rx_nxt = rx_r;
    case (rx_r)
      RX_SEARCH: begin
        if (take_bit & din_bit) begin
          rx_nxt = RX_SHIFT;
        end
      end
      RX_SHIFT: begin
        if (take_bit & (bit_cnt_r == ascd_pkg::CTRL_LAST)) begin
          rx_nxt = RX_WAIT;
        end
      end
      RX_WAIT: begin
        if (ext_load) begin
          rx_nxt = RX_BUSY;
        end else if (begin_conv & ~int_start) begin
          rx_nxt = RX_SEARCH;
        end else if (int_start) begin
          rx_nxt = RX_INT;
        end
      end
      RX_BUSY: begin
        // Re-arming once B3 is out is what allows fifteen clocks per conversion
        if (b3_out) begin
          rx_nxt = RX_SEARCH;
        end
      end
      RX_INT: begin
        if (int_done) begin
          rx_nxt = RX_SEARCH;
        end
      end
      default: begin
        rx_nxt = RX_SEARCH;
      end
    endcase
    // A select fall aborts an external conversion; an internal one runs on
    if (cs_fall & (rx_r != RX_INT)) begin
      rx_nxt = RX_SEARCH;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_r <= RX_SEARCH;
      bit_cnt_r <= 3'h0;
      ctrl_sh_r <= 6'h00;
      ctrl_r <= 7'h00;
      int_cnt_r <= '0;
    end else if (ce) begin
      rx_r <= rx_nxt;
      if (rx_r == RX_SEARCH) begin
        bit_cnt_r <= 3'h0;
      end else if ((rx_r == RX_SHIFT) & take_bit) begin
        bit_cnt_r <= bit_cnt_r + 3'h1;
        ctrl_sh_r <= {ctrl_sh_r[4:0], din_bit};
        if (bit_cnt_r == ascd_pkg::CTRL_LAST) begin
          ctrl_r <= {ctrl_sh_r, din_bit};
        end
      end
      if (int_start) begin
        int_cnt_r <= CW'(INT_CONV_CYC - 1);
      end else if ((rx_r == RX_INT) & (int_cnt_r != '0)) begin
        int_cnt_r <= int_cnt_r - 1'b1;
      end
    end
  end

  // ==========================================
  // Decoded configuration
  wire sel_hi = ctrl_byte[ascd_pkg::CB_SEL_HI];
  wire sel_mid = ctrl_byte[ascd_pkg::CB_SEL_MID];
  wire sel_lo = ctrl_byte[ascd_pkg::CB_SEL_LO];
  wire sgl_sel = ctrl_byte[ascd_pkg::CB_PAIR];
  wire uni_sel = ctrl_byte[ascd_pkg::CB_POL];
  wire [2:0] pos_sel = {sel_mid, sel_lo, sel_hi};
  wire [2:0] neg_sel = {sel_mid, sel_lo, ~sel_hi};

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      chan_pos <= 3'h0;
      chan_neg <= 3'h0;
      neg_is_ground <= 1'b1;
      polarity_unipolar <= 1'b1;
      pairing_single <= 1'b1;
      clock_mode <= ascd_pkg::MODE_INT;
      conv_start <= 1'b0;
      full_power_down <= 1'b0;
      fast_power_down <= 1'b0;
    end else if (ce) begin
      conv_start <= ext_load | int_start;
      if (begin_conv) begin
        chan_pos <= pos_sel;
        chan_neg <= sgl_sel ? 3'h0 : neg_sel;
        neg_is_ground <= sgl_sel;
        polarity_unipolar <= uni_sel;
        pairing_single <= sgl_sel;
        clock_mode <= mode_sel;
        full_power_down <= (mode_sel == ascd_pkg::MODE_FULL_PD);
        fast_power_down <= (mode_sel == ascd_pkg::MODE_FAST_PD);
      end else if (cs_fall) begin
        // Any access to the link wakes the converter
        full_power_down <= 1'b0;
        fast_power_down <= 1'b0;
      end
    end
  end

  assign conv_busy = (rx_r == RX_BUSY) | (rx_r == RX_INT);

  // ==========================================
  // Result shift-out and strobe
  logic [ascd_pkg::RES_BITS-1:0] code_fmt;
  logic [11:0] out_sh_r;
  logic dout_r;
  logic strobe_r;
  logic ext_mode_r;

  assign code_fmt = uni_sel ? sample_code : {~sample_code[ascd_pkg::RES_BITS-1], sample_code[ascd_pkg::RES_BITS-2:0]};

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      out_sh_r <= 12'h000;
      out_left_r <= 4'h0;
      dout_r <= 1'b0;
      strobe_r <= 1'b1;
      ext_mode_r <= 1'b0;
    end else if (ce) begin
      if (ext_load) begin
        ext_mode_r <= 1'b1;
        out_sh_r <= {code_fmt, 2'h0};
        out_left_r <= ascd_pkg::OUT_BITS;
        dout_r <= 1'b0;
        strobe_r <= 1'b1;
      end else if (int_start) begin
        ext_mode_r <= 1'b0;
        strobe_r <= 1'b0;
      end else if (int_done) begin
        out_sh_r <= {code_fmt, 2'h0};
        out_left_r <= ascd_pkg::OUT_BITS;
        strobe_r <= 1'b1;
      end else if (sclk_fall) begin
        if (out_left_r != 4'h0) begin
          dout_r <= out_sh_r[11];
          out_sh_r <= {out_sh_r[10:0], 1'b0};
          out_left_r <= out_left_r - 4'h1;
        end else begin
          dout_r <= 1'b0;
        end
        if (ext_mode_r) begin
          strobe_r <= 1'b0;
        end
      end else if (cs_fall & (rx_r != RX_INT)) begin
        // A new frame starts low, so the external pulse is always a true rise
        strobe_r <= 1'b0;
      end
    end
  end

  assign link.dout = dout_r;
  assign link.dout_oe = cs_low;
  assign link.strobe = strobe_r;
  // Internal clock mode keeps the strobe driven so the master can poll it
  assign link.strobe_oe = ext_mode_r ? cs_low : 1'b1;
endmodule

// ---- ascd_host.sv ----
// Serial master for the converter link, commanded over an Avalon-MM slave.
// Assumes the converter end answers within one half link period.
`timescale 1ns/1ps
module ascd_host #(
  parameter int HALF_CYC = ascd_pkg::SCLK_HALF_CYC
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic irq,
  ascd_if.host link
);
  localparam int TW = $clog2(HALF_CYC);

  generate
    // Two synchronisers and the far end output register take nine cycles before data is sampled
    if (HALF_CYC < 10) begin : g_chk
      $error("HALF_CYC below 10 lets the sampling rise miss the far end data");
    end
  endgenerate

  typedef enum logic [1:0] {H_IDLE, H_LOW, H_HIGH, H_TAIL} ascd_hst_t;

  // ==========================================
  // Pin synchronisers
  logic [1:0] s1_r;
  logic [1:0] s2_r;
  logic [1:0] s3_r;
  logic [1:0] filt_r;
  logic [1:0] prev_r;
  wire [1:0] filt_nxt = (s2_r & ~(s2_r ^ s3_r)) | (filt_r & (s2_r ^ s3_r));

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      s1_r <= 2'h0;
      s2_r <= 2'h0;
      s3_r <= 2'h0;
      filt_r <= 2'h0;
      prev_r <= 2'h0;
    end else if (ce) begin
      s1_r <= {link.strobe_line, link.dout_line};
      s2_r <= s1_r;
      s3_r <= s2_r;
      filt_r <= filt_nxt;
      prev_r <= filt_r;
    end
  end

  wire strb_rise = filt_r[ascd_pkg::LN_STRB] & ~prev_r[ascd_pkg::LN_STRB];

  // ==========================================
  // Avalon-MM slave, one wait state per access
  logic ack_r;
  logic [31:0] rdata_r;
  logic [7:0] cmd_r;
  logic [11:0] result_r;
  logic strb_seen_r;
  logic [ascd_pkg::IRQ_BITS-1:0] irq_stat_r;
  logic [ascd_pkg::IRQ_BITS-1:0] irq_en_r;
  ascd_hst_t st_r;

  wire req = avs_read | avs_write;
  wire wr_acc = avs_write & ack_r;
  wire busy = (st_r != H_IDLE);
  wire go = wr_acc & (avs_address == ascd_pkg::REG_CMD) & ~busy;
  wire clr_wr = wr_acc & (avs_address == ascd_pkg::REG_IRQ_CLR);
  wire [31:0] rd_mux =
    (avs_address == ascd_pkg::REG_CMD) ? {24'h0, cmd_r} :
    (avs_address == ascd_pkg::REG_STATUS) ? {30'h0, strb_seen_r, busy} :
    (avs_address == ascd_pkg::REG_RESULT) ? {20'h0, result_r} :
    (avs_address == ascd_pkg::REG_IRQ_STAT) ? {30'h0, irq_stat_r} :
    (avs_address == ascd_pkg::REG_IRQ_EN) ? {30'h0, irq_en_r} : 32'h0;

  assign avs_waitrequest = req & ~ack_r;
  assign avs_readdata = rdata_r;
  assign irq = |(irq_stat_r & irq_en_r);

  // ==========================================
  // Link sequencer: control byte then two zero bytes
  logic [TW-1:0] tm_r;
  logic [4:0] bits_r;
  logic [23:0] tx_r;
  logic [23:0] rx_r;
  logic cs_n_r;
  logic sclk_r;
  logic done_ev;
  wire tm_done = (tm_r == '0);
  wire [TW-1:0] tm_load = TW'(HALF_CYC - 1);
  wire [ascd_pkg::IRQ_BITS-1:0] irq_set = {strb_rise & busy, done_ev};
  wire [ascd_pkg::IRQ_BITS-1:0] irq_clr = clr_wr ? avs_writedata[ascd_pkg::IRQ_BITS-1:0] : '0;

  assign done_ev = (st_r == H_TAIL) & tm_done;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ack_r <= 1'b0;
      rdata_r <= 32'h0;
      cmd_r <= 8'h00;
      irq_en_r <= '0;
      irq_stat_r <= '0;
      strb_seen_r <= 1'b0;
    end else if (ce) begin
      ack_r <= req & ~ack_r;
      if (req & ~ack_r) begin
        rdata_r <= rd_mux;
      end
      if (go) begin
        cmd_r <= avs_writedata[7:0];
      end
      if (wr_acc & (avs_address == ascd_pkg::REG_IRQ_EN)) begin
        irq_en_r <= avs_writedata[ascd_pkg::IRQ_BITS-1:0];
      end
      // Set wins over a clear in the same cycle
      irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_set;
      if (go) begin
        strb_seen_r <= 1'b0;
      end else if (strb_rise & busy) begin
        strb_seen_r <= 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r <= H_IDLE;
      tm_r <= '0;
      bits_r <= 5'h00;
      tx_r <= 24'h0;
      rx_r <= 24'h0;
      cs_n_r <= 1'b1;
      sclk_r <= 1'b0;
      result_r <= 12'h000;
    end else if (ce) begin
      if (!tm_done) begin
        tm_r <= tm_r - 1'b1;
      end
      case (st_r)
        H_IDLE: begin
          if (go) begin
            cs_n_r <= 1'b0;
            tx_r <= {avs_writedata[7:0], 16'h0};
            bits_r <= 5'h00;
            tm_r <= tm_load;
            st_r <= H_LOW;
          end
        end
        H_LOW: begin
          if (tm_done) begin
            sclk_r <= 1'b1;
            rx_r <= {rx_r[22:0], filt_r[ascd_pkg::LN_DOUT]};
            tm_r <= tm_load;
            st_r <= H_HIGH;
          end
        end
        H_HIGH: begin
          if (tm_done) begin
            sclk_r <= 1'b0;
            tm_r <= tm_load;
            if (bits_r == ascd_pkg::XFER_LAST) begin
              st_r <= H_TAIL;
            end else begin
              bits_r <= bits_r + 5'h01;
              tx_r <= {tx_r[22:0], 1'b0};
              st_r <= H_LOW;
            end
          end
        end
        H_TAIL: begin
          if (tm_done) begin
            cs_n_r <= 1'b1;
            result_r <= rx_r[14:3];
            st_r <= H_IDLE;
          end
        end
        default: begin
          st_r <= H_IDLE;
        end
      endcase
    end
  end

  assign link.cs_n = cs_n_r;
  assign link.sclk = sclk_r;
  assign link.din = tx_r[ascd_pkg::XFER_BITS-1];
endmodule

// ---- ascd_if.sv ----
// Five-wire link between the converter end and its serial master.
// Assumes undriven outputs read low, as with a weak pull-down.
`timescale 1ns/1ps
interface ascd_if;
  logic cs_n;
  logic sclk;
  logic din;
  logic dout;
  logic dout_oe;
  logic strobe;
  logic strobe_oe;
  wire dout_line;
  wire strobe_line;
  assign dout_line = dout_oe & dout;
  assign strobe_line = strobe_oe & strobe;
  modport dev (input cs_n, input sclk, input din, output dout, output dout_oe, output strobe, output strobe_oe);
  modport host (output cs_n, output sclk, output din, input dout_line, input strobe_line);
endinterface

// ---- ascd_pkg.sv ----
// Constants shared by both ends of the converter serial command link.
// Assumes a 125 MHz system clock on both ends.
package ascd_pkg;
  // ==========================================
  // Control byte field positions
  localparam int CB_START = 7;
  localparam int CB_SEL_HI = 6;
  localparam int CB_SEL_MID = 5;
  localparam int CB_SEL_LO = 4;
  localparam int CB_POL = 3;
  localparam int CB_PAIR = 2;
  localparam int CB_MODE_HI = 1;
  localparam int CB_MODE_LO = 0;
  localparam logic [1:0] MODE_FULL_PD = 2'h0;
  localparam logic [1:0] MODE_FAST_PD = 2'h1;
  localparam logic [1:0] MODE_INT = 2'h2;
  localparam logic [1:0] MODE_EXT = 2'h3;
  localparam logic [2:0] CTRL_LAST = 3'h6;
  // ==========================================
  // Result framing
  localparam int RES_BITS = 10;
  localparam logic [3:0] OUT_BITS = 4'hc;
  localparam logic [3:0] B3_LEFT = 4'h6;
  localparam int XFER_BITS = 24;
  localparam logic [4:0] XFER_LAST = 5'h17;
  // ==========================================
  // Synchroniser lanes
  localparam int LN_SCLK = 0;
  localparam int LN_CS = 1;
  localparam int LN_DIN = 2;
  localparam int LN_DOUT = 0;
  localparam int LN_STRB = 1;
  // ==========================================
  // Timing
  localparam int SYS_CLK_MHZ = 125;
  localparam int INT_CONV_NS = 10000;
  localparam int INT_CONV_CYC = INT_CONV_NS * SYS_CLK_MHZ / 1000;
  localparam int SCLK_PERIOD_NS = 160;
  localparam int SCLK_HALF_CYC = SCLK_PERIOD_NS * SYS_CLK_MHZ / 2000;
  // ==========================================
  // Controller registers, byte offsets
  localparam logic [4:0] REG_CMD = 5'h00;
  localparam logic [4:0] REG_STATUS = 5'h04;
  localparam logic [4:0] REG_RESULT = 5'h08;
  localparam logic [4:0] REG_IRQ_STAT = 5'h0c;
  localparam logic [4:0] REG_IRQ_EN = 5'h10;
  localparam logic [4:0] REG_IRQ_CLR = 5'h14;
  localparam int ST_BUSY = 0;
  localparam int ST_STRB = 1;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_STRB = 1;
  localparam int IRQ_BITS = 2;
endpackage
